// ---- include/spt_regs.svh ----
// register map, field positions, reset values and counts of the protection timers
`ifndef SPT_REGS_SVH
`define SPT_REGS_SVH

// byte offsets within the block window
`define SPT_ADDR_PROT 8'h00
`define SPT_ADDR_WDVEC 8'h04
`define SPT_ADDR_PIC 8'h08
`define SPT_ADDR_PIT 8'h0c
`define SPT_ADDR_SVC 8'h10
`define SPT_ADDR_CAUSE 8'h14

// protection_control fields
`define SPT_PROT_WE 7
`define SPT_PROT_RSEL 6
`define SPT_PROT_WDT 5:4
`define SPT_PROT_DBF 3
`define SPT_PROT_EBM 2
`define SPT_PROT_BMT 1:0
`define SPT_PROT_RESET 8'h00

// periodic_irq_control fields
`define SPT_PIC_LEVEL 10:8
`define SPT_PIC_VECTOR 7:0
`define SPT_PIC_LEVEL_RESET 3'h0
`define SPT_PIC_VECTOR_RESET 8'h00

// periodic_timer fields
`define SPT_PIT_SWP 9
`define SPT_PIT_PTP 8
`define SPT_PIT_COUNT 7:0
`define SPT_PIT_COUNT_RESET 8'h00

// reset cause fields
`define SPT_CAUSE_LOC 0
`define SPT_CAUSE_SYS 1

`define SPT_WDVEC_RESET 8'h0f
`define SPT_VEC_NONE 8'h0f
`define SPT_SVC_KEY1 8'h55
`define SPT_SVC_KEY2 8'haa
`define SPT_WD_LEVEL 3'h7

// 512-clock prescaler, bus monitor base and external reset length
`define SPT_PRESC_MAX 9'h1ff
`define SPT_BM_BASE 10'd512
`define SPT_EXT_RST_CYCLES 10'd512
`define SPT_STRAP_TAKE 2'h2
`define SPT_STRAP_DONE 2'h3

`endif

// ---- include/spt_pkg.sv ----
// types shared by the protection timer block
package spt_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } spt_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } spt_wb_rsp_type;

    typedef struct packed {
        logic valid;
        logic [2:0] level;
    } spt_iack_req_type;

    typedef struct packed {
        logic ack;
        logic [7:0] vector;
    } spt_iack_rsp_type;

    typedef enum logic [0:0] {
        SPT_SVC_IDLE = 1'b0,
        SPT_SVC_ARMED = 1'b1
    } spt_svc_type;

    typedef struct packed {
        logic wb_ack;
        logic [31:0] rdata;
        logic [7:0] prot;
        logic prot_written;
        logic [7:0] wd_vector;
        logic [2:0] pic_level;
        logic [7:0] pic_vector;
        logic wd_prescale;
        logic pit_prescale;
        logic [7:0] pit_count;
        logic wd_act_prescale;
        logic [1:0] wd_act_timing;
        spt_svc_type svc;
        logic [8:0] wd_presc;
        logic [15:0] wd_cnt;
        logic [8:0] pit_presc;
        logic [7:0] pit_cnt;
        logic [9:0] bm_cnt;
        logic wd_pending;
        logic pit_pending;
        logic iack_ack;
        logic [7:0] iack_vector;
        logic loss_s1;
        logic loss_s2;
        logic loss_q;
        logic mode_s1;
        logic mode_s2;
        logic [1:0] strap_cnt;
        logic loc_cause;
        logic sys_cause;
        logic sys_rst_req;
        logic [9:0] ext_rst_cnt;
        logic bus_error;
    } spt_state_type;

endpackage

// ---- logic/spt_top.sv ----
// protection timers: watchdog, bus monitors, periodic timer, reset causes
//
// Local design decisions: the register addresses and register access over Wishbone.
`include "spt_regs.svh"

module spt_top #(
    parameter int WD_BASE_EXP = 9
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire spt_pkg::spt_wb_req_type wb_req,
    output spt_pkg::spt_wb_rsp_type wb_rsp,
    input wire spt_pkg::spt_iack_req_type iack_req,
    output spt_pkg::spt_iack_rsp_type iack_rsp,
    output logic [2:0] irq_level,
    input wire logic clock_mode_pin,
    input wire logic clock_loss_pin,
    input wire logic clock_loss_reset_enable,
    input wire logic osc_loop_enable,
    input wire logic reset_instr,
    input wire logic ext_cycle_active,
    input wire logic double_fault,
    output logic bus_error,
    output logic system_reset_req,
    output logic external_reset,
    output logic peripheral_reset,
    output logic clock_loss_cause,
    output logic software_reset_cause
);
    import spt_pkg::*;

    spt_state_type state;
    spt_state_type next_state;
    logic wb_go;
    logic wb_wr;
    logic [7:0] wb_addr;
    logic [15:0] merged;
    logic wd_tick;
    logic wd_timeout;
    logic pit_tick;
    logic pit_event;
    logic service;

    function automatic logic [15:0] spt_merge16(input logic [15:0] old,
                                                input logic [31:0] dat,
                                                input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction

    // terminal count of the watchdog, in watchdog ticks
    function automatic logic [15:0] spt_wd_limit(input logic [1:0] timing);
        logic [31:0] one;
        one = 32'h1;
        return 16'((one << (WD_BASE_EXP + 2 * int'(timing))) - one);
    endfunction

    // terminal count of the bus monitor
    function automatic logic [9:0] spt_bm_limit(input logic [1:0] timing);
        return (`SPT_BM_BASE >> timing) - 10'h1;
    endfunction

    assign wb_go = wb_req.cyc && wb_req.stb && !state.wb_ack;
    assign wb_wr = wb_go && wb_req.we;
    assign wb_addr = wb_req.adr[7:0];

    always_comb begin
        next_state = state;
        merged = 16'h0;
        wd_tick = 1'b0;
        wd_timeout = 1'b0;
        pit_tick = 1'b0;
        pit_event = 1'b0;
        service = 1'b0;

        // one-cycle pulses
        next_state.sys_rst_req = 1'b0;
        next_state.bus_error = 1'b0;
        next_state.iack_ack = 1'b0;

        // synchronisers for the two pins
        next_state.loss_s1 = clock_loss_pin;
        next_state.loss_s2 = state.loss_s1;
        next_state.loss_q = state.loss_s2;
        next_state.mode_s1 = clock_mode_pin;
        next_state.mode_s2 = state.mode_s1;

        // register reads
        next_state.wb_ack = wb_go;
        next_state.rdata = 32'h0;
        if (wb_go && !wb_req.we) begin
            unique case (wb_addr)
                `SPT_ADDR_PROT: next_state.rdata = {24'h0, state.prot};
                `SPT_ADDR_WDVEC: next_state.rdata = {24'h0, state.wd_vector};
                `SPT_ADDR_PIC: begin
                    next_state.rdata = {21'h0, state.pic_level, state.pic_vector};
                end
                `SPT_ADDR_PIT: begin
                    next_state.rdata = {22'h0, state.wd_prescale, state.pit_prescale,
                                        state.pit_count};
                end
                `SPT_ADDR_SVC: next_state.rdata = 32'h0;
                `SPT_ADDR_CAUSE: begin
                    next_state.rdata = {30'h0, state.sys_cause, state.loc_cause};
                end
                default: next_state.rdata = 32'h0;
            endcase
        end

        // interrupt acknowledge; cleared here so a same-cycle set below wins
        if (iack_req.valid && !state.iack_ack) begin
            next_state.iack_ack = 1'b1;
            next_state.iack_vector = `SPT_VEC_NONE;
            if (state.wd_pending && iack_req.level == `SPT_WD_LEVEL) begin
                next_state.iack_vector = state.wd_vector;
                next_state.wd_pending = 1'b0;
            end else if (state.pit_pending && iack_req.level == state.pic_level) begin
                next_state.iack_vector = state.pic_vector;
                next_state.pit_pending = 1'b0;
            end
        end

        // register writes
        if (wb_wr) begin
            unique case (wb_addr)
                `SPT_ADDR_PROT: begin
                    if (!state.prot_written && wb_req.sel[0]) begin
                        next_state.prot = wb_req.dat[7:0];
                        next_state.prot_written = 1'b1;
                    end
                end
                `SPT_ADDR_WDVEC: begin
                    if (wb_req.sel[0]) begin
                        next_state.wd_vector = wb_req.dat[7:0];
                    end
                end
                `SPT_ADDR_PIC: begin
                    merged = spt_merge16({5'h0, state.pic_level, state.pic_vector},
                                         wb_req.dat, wb_req.sel);
                    next_state.pic_level = merged[`SPT_PIC_LEVEL];
                    next_state.pic_vector = merged[`SPT_PIC_VECTOR];
                end
                `SPT_ADDR_PIT: begin
                    merged = spt_merge16({6'h0, state.wd_prescale, state.pit_prescale,
                                          state.pit_count}, wb_req.dat, wb_req.sel);
                    next_state.wd_prescale = merged[`SPT_PIT_SWP];
                    next_state.pit_prescale = merged[`SPT_PIT_PTP];
                    next_state.pit_count = merged[`SPT_PIT_COUNT];
                end
                `SPT_ADDR_SVC: begin
                    if (wb_req.sel[0]) begin
                        if (wb_req.dat[7:0] == `SPT_SVC_KEY1) begin
                            next_state.svc = SPT_SVC_ARMED;
                        end else if (wb_req.dat[7:0] == `SPT_SVC_KEY2 &&
                                     state.svc == SPT_SVC_ARMED) begin
                            next_state.svc = SPT_SVC_IDLE;
                            service = 1'b1;
                        end else begin
                            next_state.svc = SPT_SVC_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // software watchdog
        if (state.prot[`SPT_PROT_WE]) begin
            next_state.wd_presc = state.wd_presc + 9'h1;
            wd_tick = !state.wd_act_prescale || state.wd_presc == `SPT_PRESC_MAX;
            if (wd_tick) begin
                if (state.wd_cnt == spt_wd_limit(state.wd_act_timing)) begin
                    next_state.wd_cnt = 16'h0;
                    wd_timeout = 1'b1;
                end else begin
                    next_state.wd_cnt = state.wd_cnt + 16'h1;
                end
            end
        end else begin
            next_state.wd_cnt = 16'h0;
            next_state.wd_presc = 9'h0;
        end
        if (service) begin
            next_state.wd_cnt = 16'h0;
            next_state.wd_presc = 9'h0;
            next_state.wd_act_prescale = state.wd_prescale;
            next_state.wd_act_timing = state.prot[`SPT_PROT_WDT];
            wd_timeout = 1'b0;
        end
        if (wd_timeout) begin
            if (state.prot[`SPT_PROT_RSEL]) begin
                next_state.sys_rst_req = 1'b1;
                next_state.loc_cause = 1'b0;
                next_state.sys_cause = 1'b0;
            end else begin
                next_state.wd_pending = 1'b1;
            end
        end

        // periodic timer, counting whatever the level field holds
        next_state.pit_presc = state.pit_presc + 9'h1;
        pit_tick = !state.pit_prescale || state.pit_presc == `SPT_PRESC_MAX;
        if (state.pit_count == 8'h0) begin
            next_state.pit_cnt = 8'h0;
        end else if (pit_tick) begin
            if (state.pit_cnt <= 8'h1) begin
                next_state.pit_cnt = state.pit_count;
                pit_event = 1'b1;
            end else begin
                next_state.pit_cnt = state.pit_cnt - 8'h1;
            end
        end
        if (wb_wr && wb_addr == `SPT_ADDR_PIT) begin
            next_state.pit_cnt = merged[`SPT_PIT_COUNT];
        end
        if (pit_event && state.pic_level != 3'h0) begin
            next_state.pit_pending = 1'b1;
        end

        // bus monitor on internal-to-external cycles
        if (ext_cycle_active && state.prot[`SPT_PROT_EBM]) begin
            if (state.bm_cnt == spt_bm_limit(state.prot[`SPT_PROT_BMT])) begin
                next_state.bm_cnt = 10'h0;
                next_state.bus_error = 1'b1;
            end else begin
                next_state.bm_cnt = state.bm_cnt + 10'h1;
            end
        end else begin
            next_state.bm_cnt = 10'h0;
        end

        // double bus fault monitor
        if (double_fault && state.prot[`SPT_PROT_DBF]) begin
            next_state.sys_rst_req = 1'b1;
            next_state.loc_cause = 1'b0;
            next_state.sys_cause = 1'b0;
        end

        // loss of clock reference
        if (state.loss_s2 && !state.loss_q && clock_loss_reset_enable && osc_loop_enable) begin
            next_state.sys_rst_req = 1'b1;
            next_state.loc_cause = 1'b1;
            next_state.sys_cause = 1'b0;
        end

        // reset instruction: outside reset only, configuration kept
        if (state.ext_rst_cnt != 10'h0) begin
            next_state.ext_rst_cnt = state.ext_rst_cnt - 10'h1;
        end
        if (reset_instr) begin
            next_state.ext_rst_cnt = `SPT_EXT_RST_CYCLES;
            next_state.sys_cause = 1'b1;
            next_state.loc_cause = 1'b0;
        end

        // strap capture of the prescale defaults after reset release
        if (state.strap_cnt != `SPT_STRAP_DONE) begin
            next_state.strap_cnt = state.strap_cnt + 2'h1;
        end
        if (state.strap_cnt == `SPT_STRAP_TAKE) begin
            next_state.wd_prescale = !state.mode_s2;
            next_state.wd_act_prescale = !state.mode_s2;
            next_state.pit_prescale = !state.mode_s2;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
            state.prot <= `SPT_PROT_RESET;
            state.wd_vector <= `SPT_WDVEC_RESET;
            state.pic_level <= `SPT_PIC_LEVEL_RESET;
            state.pic_vector <= `SPT_PIC_VECTOR_RESET;
            state.pit_count <= `SPT_PIT_COUNT_RESET;
            state.iack_vector <= `SPT_VEC_NONE;
            state.svc <= SPT_SVC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign wb_rsp.ack = state.wb_ack;
    assign wb_rsp.dat = state.rdata;
    assign iack_rsp.ack = state.iack_ack;
    assign iack_rsp.vector = state.iack_vector;
    assign irq_level = state.wd_pending ? `SPT_WD_LEVEL :
                       (state.pit_pending ? state.pic_level : 3'h0);
    assign bus_error = state.bus_error;
    assign system_reset_req = state.sys_rst_req;
    assign external_reset = state.ext_rst_cnt != 10'h0;
    assign peripheral_reset = state.ext_rst_cnt != 10'h0;
    assign clock_loss_cause = state.loc_cause;
    assign software_reset_cause = state.sys_cause;

endmodule // spt_top

// ---- bench/spt_top_props.sv ----
// port checker for the protection timers
`include "spt_regs.svh"
module spt_top_props (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire spt_pkg::spt_wb_req_type wb_req,
    input wire spt_pkg::spt_wb_rsp_type wb_rsp,
    input wire spt_pkg::spt_iack_req_type iack_req,
    input wire spt_pkg::spt_iack_rsp_type iack_rsp,
    input wire logic [2:0] irq_level,
    input wire logic reset_instr,
    input wire logic external_reset,
    input wire logic peripheral_reset,
    input wire logic clock_loss_cause,
    input wire logic clock_loss_reset_enable,
    input wire logic osc_loop_enable
);
    import spt_pkg::*;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    logic take;
    logic rd;
    logic [7:0] wdv;
    logic [9:0] ext_len;
    assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    assign rd = take && !wb_req.we;
    // shadow of the watchdog vector and length of the outside reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wdv <= `SPT_WDVEC_RESET;
            ext_len <= 10'h0;
        end else begin
            if (take && wb_req.we && wb_req.sel[0] && wb_req.adr[7:0] == `SPT_ADDR_WDVEC) begin
                wdv <= wb_req.dat[7:0];
            end
            ext_len <= external_reset ? ext_len + 10'h1 : 10'h0;
        end
    end
    AST_WB_ACK:
        assert property (take |=> wb_rsp.ack) else $error("request not acknowledged");
    AST_ACK_PULSE:
        assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack longer than a cycle");
    AST_SVC_ZERO:
        assert property (rd && wb_req.adr[7:0] == `SPT_ADDR_SVC |=> wb_rsp.dat == 32'h0)
        else $error("service register read not zero");
    AST_PIC_RSVD:
        assert property (rd && wb_req.adr[7:0] == `SPT_ADDR_PIC |=> wb_rsp.dat[31:11] == 21'h0)
        else $error("periodic control high bits not zero");
    AST_PIT_RSVD:
        assert property (rd && wb_req.adr[7:0] == `SPT_ADDR_PIT |=> wb_rsp.dat[31:10] == 22'h0)
        else $error("periodic timer high bits not zero");
    AST_WD_IACK:
        assert property (iack_req.valid && iack_req.level == 3'h7 && !iack_rsp.ack
            && irq_level == 3'h7 |=> iack_rsp.ack && iack_rsp.vector == wdv)
        else $error("watchdog acknowledge vector wrong");
    AST_EXT_START:
        assert property (reset_instr |=> external_reset && peripheral_reset)
        else $error("reset instruction did not reset outside");
    AST_EXT_LEN:
        assert property ($fell(external_reset) |-> ext_len == `SPT_EXT_RST_CYCLES)
        else $error("outside reset length wrong");
    AST_LOC:
        assert property ($rose(clock_loss_cause) |->
            $past(clock_loss_reset_enable) && $past(osc_loop_enable))
        else $error("clock loss cause set while not enabled");
    cover property (rd ##1 wb_rsp.ack);
    cover property (iack_rsp.ack && irq_level == 3'h7);
    cover property ($fell(external_reset));
endmodule // spt_top_props

bind spt_top spt_top_props spt_top_props_i (.clk_sys, .rstn, .wb_req, .wb_rsp, .iack_req,
    .iack_rsp, .irq_level, .reset_instr, .external_reset, .peripheral_reset, .clock_loss_cause,
    .clock_loss_reset_enable, .osc_loop_enable);

// ---- bench/spt_core_model.sv ----
// processor side model answering interrupt requests with acknowledge cycles
module spt_core_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic en,
    input wire logic [2:0] irq_level,
    input wire spt_pkg::spt_iack_rsp_type iack_rsp,
    output spt_pkg::spt_iack_req_type iack_req,
    output int n_ack,
    output logic [7:0] last_vec,
    output logic [2:0] last_lvl
);
    import spt_pkg::*;
    logic busy;
    logic [2:0] lvl;
    assign iack_req.valid = busy;
    // level lines flip when idle so stale values are never trusted
    assign iack_req.level = busy ? lvl : ~lvl;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            lvl <= 3'h0;
            n_ack <= 0;
            last_vec <= 8'h00;
            last_lvl <= 3'h0;
        end else if (busy) begin
            if (iack_rsp.ack) begin
                busy <= 1'b0;
                last_vec <= iack_rsp.vector;
                last_lvl <= lvl;
                n_ack <= n_ack + 1;
            end
        end else if (en && irq_level != 3'h0) begin
            busy <= 1'b1;
            lvl <= irq_level;
        end
    end
endmodule // spt_core_model

// ---- bench/tb_top.sv ----
// self-checking bench for the protection timers
`include "spt_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
`define WAITC(cond, lim) c = 0; while (!(cond) && c < lim) begin @(posedge clk_sys); c++; end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spt_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    spt_wb_req_type wb_req = '0;
    spt_wb_rsp_type wb_rsp;
    spt_iack_req_type iack_req;
    spt_iack_rsp_type iack_rsp;
    logic [2:0] irq_level, last_lvl;
    logic clock_mode_pin = 1'b1;
    logic clock_loss_pin = 1'b0;
    logic clock_loss_reset_enable = 1'b0;
    logic osc_loop_enable = 1'b1;
    logic reset_instr = 1'b0;
    logic ext_cycle_active = 1'b0;
    logic double_fault = 1'b0;
    logic en = 1'b0;
    logic bus_error, system_reset_req, external_reset, peripheral_reset;
    logic clock_loss_cause, software_reset_cause;
    logic [7:0] last_vec;
    int n_ack, c, n1;
    int n_fail = 0;
    int n_checks = 0;
    logic [31:0] v, e;
    logic [31:0] seed = 32'he2e0a056;
    logic [31:0] exq[$];
    spt_top #(.WD_BASE_EXP(2)) spt_top_i (.clk_sys, .rstn, .wb_req, .wb_rsp, .iack_req,
        .iack_rsp, .irq_level, .clock_mode_pin, .clock_loss_pin, .clock_loss_reset_enable,
        .osc_loop_enable, .reset_instr, .ext_cycle_active, .double_fault, .bus_error,
        .system_reset_req, .external_reset, .peripheral_reset, .clock_loss_cause,
        .software_reset_cause);
    spt_core_model spt_core_model_i (.clk_sys, .rstn, .en, .irq_level, .iack_rsp, .iack_req,
        .n_ack, .last_vec, .last_lvl);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one classic cycle; the expected read data goes on the queue
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] x);
        exq.push_back(we ? 32'h0 : x);
        wb_req <= '{1'b1, 1'b1, we, {24'h0, a}, 4'h3, d};
        // no limit of its own: only the watchdog process ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (wb_rsp.ack !== 1'b1);
        wb_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic do_reset(input logic mode);
        rstn <= 1'b0;
        clock_mode_pin <= mode;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (wb_rsp.ack === 1'b1) begin
            e = exq.pop_front();
            `CHK("wb_dat", e, wb_rsp.dat)
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end
    initial begin
        do_reset(1'b1);
        v = rnd();
        wb(0, `SPT_ADDR_WDVEC, 0, 32'h0f);
        wb(0, `SPT_ADDR_PIT, 0, 32'h0);
        wb(0, `SPT_ADDR_SVC, 0, 32'h0);
        wb(0, 8'h20, 0, 32'h0);
        wb(1, `SPT_ADDR_WDVEC, v, 0);
        wb(0, `SPT_ADDR_WDVEC, 0, {24'h0, v[7:0]});
        wb(1, `SPT_ADDR_PIT, 32'hffff, 0);
        wb(0, `SPT_ADDR_PIT, 0, 32'h3ff);
        wb(1, `SPT_ADDR_PIT, 32'h0, 0);
        wb(1, `SPT_ADDR_PIC, 32'hffff, 0);
        wb(0, `SPT_ADDR_PIC, 0, 32'h7ff);
        wb(1, `SPT_ADDR_PIC, 32'h0, 0);
        wb(1, `SPT_ADDR_PROT, 32'hbf, 0);
        wb(1, `SPT_ADDR_PROT, 32'h00, 0);
        wb(0, `SPT_ADDR_PROT, 0, 32'hbf);
        `CHK("irq_level", 3'h7, irq_level)
        en <= 1'b1;
        wb(1, `SPT_ADDR_SVC, `SPT_SVC_KEY1, 0);
        wb(1, `SPT_ADDR_SVC, `SPT_SVC_KEY2, 0);
        repeat (8) @(posedge clk_sys);
        n1 = n_ack;
        `WAITC(n_ack > n1, 400)
        `CHK("wd_period", 1'b1, (c > 238 && c < 256))
        `CHK("wd_vec", v[7:0], last_vec)
        en <= 1'b0;
        ext_cycle_active <= 1'b1;
        `WAITC(bus_error === 1'b1, 100)
        ext_cycle_active <= 1'b0;
        `CHK("bm_time", 1'b1, (c > 61 && c < 69))
        double_fault <= 1'b1;
        @(posedge clk_sys);
        double_fault <= 1'b0;
        `WAITC(system_reset_req === 1'b1, 6)
        `CHK("dbf_reset", 1'b1, system_reset_req)
        clock_loss_pin <= 1'b1;
        repeat (10) @(posedge clk_sys);
        clock_loss_pin <= 1'b0;
        `CHK("loss_off", 1'b0, clock_loss_cause)
        do_reset(1'b0);
        wb(0, `SPT_ADDR_PIT, 0, 32'h300);
        wb(1, `SPT_ADDR_PROT, 32'h48, 0);
        wb(1, `SPT_ADDR_PIC, 32'h340, 0);
        wb(1, `SPT_ADDR_PIT, 32'h005, 0);
        en <= 1'b1;
        n1 = n_ack;
        `WAITC(n_ack > n1 + 1, 40)
        `CHK("pit_acks", 1'b1, c < 40)
        `CHK("pit_vec", 8'h40, last_vec)
        `CHK("pit_lvl", 3'h3, last_lvl)
        wb(1, `SPT_ADDR_PIC, 32'h040, 0);
        repeat (10) @(posedge clk_sys);
        n1 = n_ack;
        repeat (30) @(posedge clk_sys);
        `CHK("lvl0_quiet", n1, n_ack)
        wb(1, `SPT_ADDR_PIT, 32'h0, 0);
        wb(1, `SPT_ADDR_PIC, 32'h340, 0);
        repeat (10) @(posedge clk_sys);
        n1 = n_ack;
        repeat (20) @(posedge clk_sys);
        `CHK("cnt0_stop", n1, n_ack)
        en <= 1'b0;
        reset_instr <= 1'b1;
        @(posedge clk_sys);
        reset_instr <= 1'b0;
        `WAITC(external_reset === 1'b1, 4)
        wb(0, `SPT_ADDR_PROT, 0, 32'h48);
        wb(0, `SPT_ADDR_PIC, 0, 32'h340);
        `CHK("sw_cause", 1'b1, software_reset_cause)
        `WAITC(external_reset === 1'b0, 600)
        `CHK("ext_len", 1'b1, (c > 498 && c < 512))
        clock_loss_reset_enable <= 1'b1;
        clock_loss_pin <= 1'b1;
        `WAITC(clock_loss_cause === 1'b1, 10)
        `CHK("loss_on", 1'b1, clock_loss_cause)
        `CHK("queue", 0, exq.size())
        report_and_stop();
    end
endmodule // tb_top
